// File: rtl/ufdc_fifo.sv
// Thirty-two character FIFO with clear and holding-register mode
`timescale 1ns/100ps
`include "ufdc_params.svh"
module ufdc_fifo (
  // Clock and reset
  input wire logic   sys_clk_i,
  input wire logic   reset_i,
  // Control side
  ufdc_fifo_if.store fifo
);
  import ufdc_pkg::*;

  ufdc_byte_t            mem [`UFDC_DEPTH];  // Character store
  logic [`UFDC_PTR_W-1:0] wr_ptr;             // Next free slot
  logic [`UFDC_PTR_W-1:0] rd_ptr;             // Head slot
  ufdc_cnt_t              count;              // Characters held
  logic [`UFDC_PTR_W-1:0] next_wr_ptr;
  logic [`UFDC_PTR_W-1:0] next_rd_ptr;
  ufdc_cnt_t              next_count;
  logic                   do_push;            // Accepted write
  logic                   do_pop;             // Accepted read
  ufdc_cnt_t              limit;              // Usable depth

  // With FIFOs off only one character fits, like a bare holding register
  assign limit       = fifo.single ? `UFDC_HOLD_DEPTH : `UFDC_DEPTH;
  assign fifo.full   = (count >= limit);
  assign fifo.empty  = (count == `UFDC_CNT_ZERO);
  assign fifo.count  = count;
  assign fifo.rdata  = mem[rd_ptr];
  assign do_push     = fifo.push && !fifo.full;
  assign do_pop      = fifo.pop && !fifo.empty;

  // Pointer and count update; clear wins over anything in the same cycle
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (fifo.clear) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = `UFDC_CNT_ZERO;
    end else begin
      if (do_push) begin
        next_wr_ptr = wr_ptr + 1'b1;
      end
      if (do_pop) begin
        next_rd_ptr = rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        next_count = count + 1'b1;
      end else if (do_pop && !do_push) begin
        next_count = count - 1'b1;
      end
    end
  end

  // Register pointers; the store itself needs no reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= `UFDC_CNT_ZERO;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (do_push && !fifo.clear) begin
      mem[wr_ptr] <= fifo.wdata;
    end
  end
endmodule : ufdc_fifo

// File: rtl/ufdc_fifo_if.sv
// Carrier between the control logic and one character FIFO
`timescale 1ns/100ps
interface ufdc_fifo_if;
  import ufdc_pkg::*;
  logic       push;   // Write one character
  logic       pop;    // Drop head character
  logic       clear;  // Empty the store and pointers
  logic       single; // Behave as a one-character holding register
  ufdc_byte_t wdata;  // Character to write
  ufdc_byte_t rdata;  // Head character
  ufdc_cnt_t  count;  // Characters held
  logic       full;   // No room left
  logic       empty;  // Nothing held
  modport ctrl  (output push, pop, clear, single, wdata, input rdata, count, full, empty);
  modport store (input push, pop, clear, single, wdata, output rdata, count, full, empty);
endinterface : ufdc_fifo_if

// File: rtl/ufdc_params.svh
// Constants of the UART FIFO and DMA control block
// How it works
// - Mode 0 raises interrupts per single character
// - Mode 0 transmit request low when transmit empty
// - Mode 0 receive request low while data held
// - Mode 1 transmit request high full, low at trigger
// - Mode 1 receive request low at trigger/time-out until empty
// - Mode 1 receive request stays low above trigger
// - Receive interrupt at trigger; FIFO fills to full
// - Transmit interrupt when count below transmit trigger
// - Control bit 3 picks DMA mode, reset mode 0
// - Control bit 2 empties transmit FIFO, self-clears
// - Control bit 1 empties receive FIFO, self-clears
// - Control bit 0 enables both FIFOs, reset off
// - Other control bits written only with enable set
// - Bits 7:6 receive trigger 8/16/24/28
// - Bits 5:4 transmit trigger 16/8/24/30
// - Receive interrupt clears below trigger level
`ifndef UFDC_PARAMS_SVH
`define UFDC_PARAMS_SVH
`define UFDC_DEPTH      6'h20
`define UFDC_CNT_W      6
`define UFDC_PTR_W      5
`define UFDC_HOLD_DEPTH 6'h01
`define UFDC_CNT_ZERO   6'h00
`define UFDC_ADDR_W     12
`define UFDC_OFF_DATA   12'h000
`define UFDC_OFF_FCTL   12'h008
`define UFDC_OFF_STAT   12'h00c
`define UFDC_FC_EN      0
`define UFDC_FC_RXCLR   1
`define UFDC_FC_TXCLR   2
`define UFDC_FC_DMA     3
`define UFDC_FC_TXT     5:4
`define UFDC_FC_RXT     7:6
`define UFDC_ST_RXCNT   5:0
`define UFDC_ST_TXCNT   13:8
`define UFDC_ST_RXREQ   16
`define UFDC_ST_TXREQ   17
`define UFDC_ST_RXIRQ   18
`define UFDC_ST_TXIRQ   19
`define UFDC_ST_EN      20
`define UFDC_RXT_0      6'h08
`define UFDC_RXT_1      6'h10
`define UFDC_RXT_2      6'h18
`define UFDC_RXT_3      6'h1c
`define UFDC_TXT_0      6'h10
`define UFDC_TXT_1      6'h08
`define UFDC_TXT_2      6'h18
`define UFDC_TXT_3      6'h1e
`define UFDC_TXREQ_RST  1'b0
`define UFDC_RXREQ_RST  1'b1
`endif

// File: rtl/ufdc_pkg.sv
// Types shared by the UART FIFO and DMA control block
`include "ufdc_params.svh"
package ufdc_pkg;
  typedef logic [7:0]             ufdc_byte_t;      // One character
  typedef logic [`UFDC_CNT_W-1:0] ufdc_cnt_t;       // Fill count 0..32
  typedef logic [1:0]             ufdc_trig_code_t; // Trigger select code
  typedef enum logic {
    UFDC_DMA_MODE0 = 1'b0,
    UFDC_DMA_MODE1 = 1'b1
  } ufdc_dma_mode_t;
endpackage : ufdc_pkg

// File: rtl/ufdc_top.sv
// UART FIFO control, DMA request pins and trigger interrupts behind APB
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "ufdc_params.svh"
module ufdc_top (
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  // APB slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [`UFDC_ADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic [31:0]                   prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // Transmit shifter side
  input  wire logic                     tx_pop_i,
  output ufdc_pkg::ufdc_byte_t          tx_data_o,
  output logic                          tx_valid_o,
  // Receive shifter side
  input  wire logic                     rx_push_i,
  input  wire ufdc_pkg::ufdc_byte_t     rx_data_i,
  input  wire logic                     rx_timeout_i,
  output logic                          rx_full_o,
  // DMA request pins, active low
  output logic                          tx_dma_request_n_o,
  output logic                          rx_dma_request_n_o,
  // Interrupt requests and enable state towards the status encoder
  output logic                          rx_data_irq_o,
  output logic                          tx_empty_irq_o,
  output logic                          fifo_enabled_o
);
  import ufdc_pkg::*;

  // FIFO carriers
  ufdc_fifo_if tx_if ();
  ufdc_fifo_if rx_if ();

  // Control register fields
  logic            fifo_en;       // Both FIFOs on
  ufdc_dma_mode_t  dma_mode;      // DMA request style
  ufdc_trig_code_t rx_code;       // Receive trigger select
  ufdc_trig_code_t tx_code;       // Transmit trigger select
  logic            next_fifo_en;
  ufdc_dma_mode_t  next_dma_mode;
  ufdc_trig_code_t next_rx_code;
  ufdc_trig_code_t next_tx_code;

  // Bus decode
  logic            setup_rd;      // Setup cycle of a read
  logic            access;        // Access cycle, the transfer's effective edge
  logic            hit_data;      // Holding register window
  logic            hit_fctl;      // FIFO control register
  logic            hit_stat;      // Status register
  logic            hit_any;       // Any mapped word
  logic            fctl_wr;       // Control register written now
  logic            tx_clear_req;  // Transmit FIFO clear pulse
  logic            rx_clear_req;  // Receive FIFO clear pulse
  logic            en_change;     // Enable toggles this edge
  logic [31:0]     rd_word;       // Read data chosen in setup
  logic [31:0]     next_prdata;
  logic [31:0]     stat_word;     // Live status image
  logic [7:0]      fctl_word;     // Control readback image

  // Trigger levels and request state
  ufdc_cnt_t       rx_level;      // Receive trigger in characters
  ufdc_cnt_t       tx_level;      // Transmit trigger in characters
  logic            block_mode;    // FIFOs on and DMA mode 1
  logic            next_tx_req_n;
  logic            next_rx_req_n;
  logic            next_rx_irq;
  logic            next_tx_irq;
  logic            rx_has_data;   // Receive side holds characters
  logic            tx_has_data;   // Transmit side holds characters

  // Trigger level decode
  ufdc_trig u_trig (
    .rx_code_i  (rx_code),
    .tx_code_i  (tx_code),
    .rx_level_o (rx_level),
    .tx_level_o (tx_level)
  );

  // Transmit store, filled from the bus and drained by the shifter
  ufdc_fifo u_tx_fifo (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .fifo      (tx_if.store)
  );

  // Receive store, filled by the shifter and drained from the bus
  ufdc_fifo u_rx_fifo (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .fifo      (rx_if.store)
  );

  // APB decode; zero wait states, so pready simply stays high
  assign setup_rd  = psel_i && !penable_i && !pwrite_i;
  assign access    = psel_i && penable_i;
  always_comb begin
    hit_data = 1'b0;
    hit_fctl = 1'b0;
    hit_stat = 1'b0;
    if (paddr_i == `UFDC_OFF_DATA) begin
      hit_data = 1'b1;
    end else if (paddr_i == `UFDC_OFF_FCTL) begin
      hit_fctl = 1'b1;
    end else if (paddr_i == `UFDC_OFF_STAT) begin
      hit_stat = 1'b1;
    end
  end
  assign hit_any   = hit_data || hit_fctl || hit_stat;
  assign pready_o  = 1'b1;
  // Unmapped words answer with an error; writes to status are also refused
  assign pslverr_o = access && (!hit_any || (hit_stat && pwrite_i));
  assign fctl_wr   = access && pwrite_i && hit_fctl;

  // Control register update
  always_comb begin
    next_fifo_en  = fifo_en;
    next_dma_mode = dma_mode;
    next_rx_code  = rx_code;
    next_tx_code  = tx_code;
    if (fctl_wr) begin
      next_fifo_en = pwdata_i[`UFDC_FC_EN];
      // Other fields only take a write that also sets the enable bit
      if (pwdata_i[`UFDC_FC_EN]) begin
        next_dma_mode = ufdc_dma_mode_t'(pwdata_i[`UFDC_FC_DMA]);
        next_rx_code  = pwdata_i[`UFDC_FC_RXT];
        next_tx_code  = pwdata_i[`UFDC_FC_TXT];
      end
    end
  end

  // Control register flops; reset leaves FIFOs off and mode 0
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      fifo_en  <= 1'b0;
      dma_mode <= UFDC_DMA_MODE0;
      rx_code  <= 2'h0;
      tx_code  <= 2'h0;
    end else begin
      fifo_en  <= next_fifo_en;
      dma_mode <= next_dma_mode;
      rx_code  <= next_rx_code;
      tx_code  <= next_tx_code;
    end
  end

  // Clear pulses act at the write edge and leave no stored bit behind,
  // so the clear bits read back as zero by themselves.
  // Switching the enable also flushes both stores so that stale
  // characters never outlive a change of depth.
  assign en_change    = fctl_wr && (pwdata_i[`UFDC_FC_EN] != fifo_en);
  assign tx_clear_req = (fctl_wr && pwdata_i[`UFDC_FC_EN] && pwdata_i[`UFDC_FC_TXCLR])
                        || en_change;
  assign rx_clear_req = (fctl_wr && pwdata_i[`UFDC_FC_EN] && pwdata_i[`UFDC_FC_RXCLR])
                        || en_change;

  // Transmit FIFO connection; the shift register is outside and untouched
  assign tx_if.push   = access && pwrite_i && hit_data;
  assign tx_if.wdata  = pwdata_i[7:0];
  assign tx_if.pop    = tx_pop_i;
  assign tx_if.clear  = tx_clear_req;
  assign tx_if.single = !fifo_en;
  assign tx_data_o    = tx_if.rdata;
  assign tx_valid_o   = !tx_if.empty;

  // Receive FIFO connection; keeps taking characters until full
  assign rx_if.push   = rx_push_i;
  assign rx_if.wdata  = rx_data_i;
  assign rx_if.pop    = access && !pwrite_i && hit_data;
  assign rx_if.clear  = rx_clear_req;
  assign rx_if.single = !fifo_en;
  assign rx_full_o    = rx_if.full;

  // Readback images
  always_comb begin
    fctl_word                = 8'h00;
    fctl_word[`UFDC_FC_EN]   = fifo_en;
    fctl_word[`UFDC_FC_DMA]  = dma_mode;
    fctl_word[`UFDC_FC_RXT]  = rx_code;
    fctl_word[`UFDC_FC_TXT]  = tx_code;
    stat_word                = 32'h0000_0000;
    stat_word[`UFDC_ST_RXCNT] = rx_if.count;
    stat_word[`UFDC_ST_TXCNT] = tx_if.count;
    stat_word[`UFDC_ST_RXREQ] = rx_dma_request_n_o;
    stat_word[`UFDC_ST_TXREQ] = tx_dma_request_n_o;
    stat_word[`UFDC_ST_RXIRQ] = rx_data_irq_o;
    stat_word[`UFDC_ST_TXIRQ] = tx_empty_irq_o;
    stat_word[`UFDC_ST_EN]    = fifo_en;
  end

  // Read data is picked in the setup cycle so prdata comes from a flop.
  // An empty receive store reads as zero and is not popped.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_data) begin
      if (!rx_if.empty) begin
        rd_word = {24'h00_0000, rx_if.rdata};
      end
    end else if (hit_fctl) begin
      rd_word = {24'h00_0000, fctl_word};
    end else if (hit_stat) begin
      rd_word = stat_word;
    end
    next_prdata = setup_rd ? rd_word : prdata_o;
  end

  // Read data register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else begin
      prdata_o <= next_prdata;
    end
  end

  // Request and interrupt decisions
  assign block_mode  = fifo_en && (dma_mode == UFDC_DMA_MODE1);
  assign rx_has_data = !rx_if.empty;
  assign tx_has_data = !tx_if.empty;

  always_comb begin
    next_tx_req_n = tx_dma_request_n_o;
    next_rx_req_n = rx_dma_request_n_o;
    if (!block_mode) begin
      // Single-character style, FIFOs on or off
      next_tx_req_n = tx_has_data;
      next_rx_req_n = !rx_has_data;
    end else begin
      // Transmit: high once full, low again when drained to the trigger
      if (tx_if.count == `UFDC_DEPTH) begin
        next_tx_req_n = 1'b1;
      end else if (tx_if.count <= tx_level) begin
        next_tx_req_n = 1'b0;
      end
      // Receive: armed by trigger or time-out, released only when empty
      if (!rx_has_data) begin
        next_rx_req_n = 1'b1;
      end else if ((rx_if.count >= rx_level) || rx_timeout_i) begin
        next_rx_req_n = 1'b0;
      end
    end
    // Interrupts: per character unless in block mode
    if (block_mode) begin
      next_rx_irq = (rx_if.count >= rx_level);
      next_tx_irq = (tx_if.count < tx_level);
    end else begin
      next_rx_irq = rx_has_data;
      next_tx_irq = !tx_has_data;
    end
  end

  // Request and interrupt flops; one cycle behind the counts
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_dma_request_n_o <= `UFDC_TXREQ_RST;
      rx_dma_request_n_o <= `UFDC_RXREQ_RST;
      rx_data_irq_o      <= 1'b0;
      tx_empty_irq_o     <= 1'b1;
    end else begin
      tx_dma_request_n_o <= next_tx_req_n;
      rx_dma_request_n_o <= next_rx_req_n;
      rx_data_irq_o      <= next_rx_irq;
      tx_empty_irq_o     <= next_tx_irq;
    end
  end

  // Enable state for the status encoder
  assign fifo_enabled_o = fifo_en;
endmodule : ufdc_top

// File: rtl/ufdc_trig.sv
// Trigger level decode for both directions
`timescale 1ns/100ps
`include "ufdc_params.svh"
module ufdc_trig (
  // Trigger select codes
  input  wire ufdc_pkg::ufdc_trig_code_t rx_code_i,
  input  wire ufdc_pkg::ufdc_trig_code_t tx_code_i,
  // Decoded levels in characters
  output ufdc_pkg::ufdc_cnt_t            rx_level_o,
  output ufdc_pkg::ufdc_cnt_t            tx_level_o
);
  import ufdc_pkg::*;

  // Receive levels
  always_comb begin
    case (rx_code_i)
      2'h0:    rx_level_o = `UFDC_RXT_0;
      2'h1:    rx_level_o = `UFDC_RXT_1;
      2'h2:    rx_level_o = `UFDC_RXT_2;
      default: rx_level_o = `UFDC_RXT_3;
    endcase
  end

  // Transmit levels; code zero is the reset default
  always_comb begin
    case (tx_code_i)
      2'h0:    tx_level_o = `UFDC_TXT_0;
      2'h1:    tx_level_o = `UFDC_TXT_1;
      2'h2:    tx_level_o = `UFDC_TXT_2;
      default: tx_level_o = `UFDC_TXT_3;
    endcase
  end
endmodule : ufdc_trig

// File: sim/uart_fifo_dma_control_tb_top.sv
// Self-checking bench for the FIFO control and DMA request block
`timescale 1ns/100ps
`include "ufdc_params.svh"
module uart_fifo_dma_control_tb_top;
  import ufdc_pkg::*;
  // Trigger code beside the levels it selects
  typedef struct { logic [1:0] code; int rxl; int txl; } ufdc_row_t;
  ufdc_row_t rows [4] = '{'{2'h0, 8, 16}, '{2'h1, 16, 8}, '{2'h2, 24, 24}, '{2'h3, 28, 30}};
  logic clk = 1'b0, rst = 1'b1, tx_pop = 1'b0, rx_push = 1'b0, rx_timeout = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, tx_valid, rx_full, err;
  logic tx_req_n, rx_req_n, rx_irq, tx_irq, fifo_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  ufdc_byte_t tx_data, base, rx_data = 8'h00, rx_seq = 8'h30;
  int errors = 0, n_checks = 0;
  always #2 clk = ~clk;
  ufdc_top DUT (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .tx_pop_i(tx_pop), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .rx_push_i(rx_push), .rx_data_i(rx_data),
    .rx_timeout_i(rx_timeout), .rx_full_o(rx_full), .tx_dma_request_n_o(tx_req_n),
    .rx_dma_request_n_o(rx_req_n), .rx_data_irq_o(rx_irq), .tx_empty_irq_o(tx_irq), .fifo_enabled_o(fifo_en));
  ufdc_host_model host (.sys_clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Let edges pass, then step off the edge so outputs are settled
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, rdv, err);
  endtask : rd
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdv, err);
  endtask : wr
  // Receiver pushes n characters on consecutive edges
  task push(input int n);
    repeat (n) begin
      @(posedge clk);
      rx_push <= 1'b1;
      rx_data <= rx_seq;
      rx_seq  <= rx_seq + 8'h01;
    end
    @(posedge clk);
    rx_push <= 1'b0;
    cyc(2);
  endtask : push
  task pop_tx(input int n);
    repeat (n) begin
      @(posedge clk);
      tx_pop <= 1'b1;
    end
    @(posedge clk);
    tx_pop <= 1'b0;
    cyc(2);
  endtask : pop_tx
  task pulse_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
  endtask : pulse_reset
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // Watchdog sized well above the several hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    pulse_reset();
    // Trigger rows, block mode, both stores cleared per row
    foreach (rows[i]) begin
      host.ctl({rows[i].code, rows[i].code, 4'b1110});
      rd(`UFDC_OFF_FCTL);
      chk(rdv, {24'h0, rows[i].code, rows[i].code, 4'b1001});
      push(rows[i].rxl - 1);
      chk({rx_irq, rx_req_n}, 2'b01);
      push(1);
      chk({rx_irq, rx_req_n}, 2'b10);
      push(2);
      rd(`UFDC_OFF_DATA);
      cyc(2);
      chk(rx_req_n, 1'b0);
      // Drain below the trigger: interrupt drops, request waits for empty
      rd(`UFDC_OFF_DATA);
      rd(`UFDC_OFF_DATA);
      cyc(2);
      chk({rx_irq, rx_req_n}, 2'b00);
      for (int k = 0; k < rows[i].txl; k++) wr(`UFDC_OFF_DATA, k);
      cyc(2);
      chk({tx_irq, tx_req_n, tx_data}, 10'h000);
      pop_tx(1);
      chk({tx_irq, tx_data}, 9'h101);
      $display("trigger row %0d done", i);
    end
    // Fill both stores past full; tx request holds until back at trigger
    repeat (4) wr(`UFDC_OFF_DATA, 32'h77);
    push(6);
    rd(`UFDC_OFF_STAT);
    chk({rdv[13:8], rdv[5:0], tx_req_n, rx_full}, {6'h20, 6'h20, 2'b11});
    pop_tx(1);
    chk(tx_req_n, 1'b1);
    pop_tx(1);
    chk(tx_req_n, 1'b0);
    host.ctl(8'hfa);
    rd(`UFDC_OFF_STAT);
    chk({rdv[13:8], rdv[5:0]}, {6'h1e, 6'h00});
    host.ctl(8'hfc);
    rd(`UFDC_OFF_STAT);
    chk({rdv[13:8], rdv[5:0]}, 12'h000);
    $display("full and clear test done");
    // Time-out below trigger drives the rx request low until empty
    base = rx_seq;
    push(3);
    chk(rx_req_n, 1'b1);
    @(posedge clk);
    rx_timeout <= 1'b1;
    @(posedge clk);
    rx_timeout <= 1'b0;
    cyc(2);
    chk(rx_req_n, 1'b0);
    for (int j = 0; j < 3; j++) begin
      rd(`UFDC_OFF_DATA);
      chk(rdv[7:0], base + 8'(j));
    end
    cyc(2);
    chk(rx_req_n, 1'b1);
    $display("time-out test done");
    // FIFOs on in mode 0: per character pins and interrupts
    host.ctl(8'h06);
    push(1);
    chk({rx_req_n, rx_irq, tx_req_n, tx_irq}, 4'b0101);
    wr(`UFDC_OFF_DATA, 32'h11);
    cyc(2);
    chk({tx_req_n, tx_irq}, 2'b10);
    $display("mode 0 test done");
    // Enable cleared; other bits of that write ignored
    wr(`UFDC_OFF_FCTL, 32'hb8);
    rd(`UFDC_OFF_FCTL);
    chk({rdv, fifo_en}, {32'h00, 1'b0});
    wr(`UFDC_OFF_DATA, 32'h5a);
    cyc(2);
    chk({tx_req_n, tx_valid, tx_data}, 10'h35a);
    pop_tx(1);
    chk({tx_req_n, tx_irq}, 2'b01);
    base = rx_seq;
    push(1);
    chk({rx_req_n, rx_irq, rx_full}, 3'b011);
    rd(`UFDC_OFF_DATA);
    cyc(2);
    chk({rdv[7:0], rx_req_n}, {base, 1'b1});
    rd(12'h004);
    chk({err, rdv}, {1'b1, 32'h0});
    $display("fifos off test done");
    // Reset in mid-run restores defaults
    host.ctl(8'h08);
    pulse_reset();
    chk({tx_req_n, rx_req_n, rx_irq, tx_irq, fifo_en}, 5'b01010);
    rd(`UFDC_OFF_FCTL);
    chk(rdv, 32'h0);
    $display("reset test done");
    print_verdict();
  end
endmodule : uart_fifo_dma_control_tb_top

// File: sim/ufdc_assertions.sv
// Port-level checker for the FIFO control and DMA request block
`timescale 1ns/100ps
`include "ufdc_params.svh"
module ufdc_assertions (
  // Clock and reset
  input wire logic                    sys_clk_i,
  input wire logic                    reset_i,
  // APB side
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic                    pwrite_i,
  input wire logic [`UFDC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]             pwdata_i,
  input wire logic                    pslverr_o,
  // FIFO levels, pins and interrupts
  input wire logic                    tx_valid_o,
  input wire logic                    rx_full_o,
  input wire logic                    tx_dma_request_n_o,
  input wire logic                    rx_dma_request_n_o,
  input wire logic                    rx_data_irq_o,
  input wire logic                    tx_empty_irq_o,
  input wire logic                    fifo_enabled_o
);
  import ufdc_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Control write completing at this edge
  logic ctl_wr;
  assign ctl_wr = psel_i && penable_i && pwrite_i && (paddr_i == `UFDC_OFF_FCTL);
  // With FIFOs off the store is one deep, so full equals holding a character
  property p_tx_off; !fifo_enabled_o |=> tx_dma_request_n_o == $past(tx_valid_o); endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx request wrong with fifos off");
  property p_rx_off; !fifo_enabled_o |=> rx_dma_request_n_o == !$past(rx_full_o); endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx request wrong with fifos off");
  property p_irq_off;
    !fifo_enabled_o |=> (rx_data_irq_o == $past(rx_full_o)) && (tx_empty_irq_o == !$past(tx_valid_o));
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("per character interrupt wrong");
  // A full store is above every trigger level in either mode
  property p_full; fifo_enabled_o && rx_full_o |=> !rx_dma_request_n_o && rx_data_irq_o; endproperty
  a_full: assert property (p_full) else $error("full rx store not requesting");
  property p_err; !(psel_i && penable_i) |-> !pslverr_o; endproperty
  a_err: assert property (p_err) else $error("error outside access phase");
  property p_enable_wr; ctl_wr |=> fifo_enabled_o == $past(pwdata_i[0]); endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable bit not taken");
  property p_rx_clr; ctl_wr && pwdata_i[0] && pwdata_i[1] |=> !rx_full_o ##1 rx_dma_request_n_o; endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx clear incomplete");
  property p_tx_clr;
    ctl_wr && pwdata_i[0] && pwdata_i[2] |=> !tx_valid_o ##1 (tx_empty_irq_o && !tx_dma_request_n_o);
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx clear incomplete");
  // Main scenarios reached
  c_full: cover property (fifo_enabled_o && rx_full_o);
  c_off_tx: cover property (!fifo_enabled_o && tx_valid_o);
  c_err: cover property (pslverr_o);
endmodule : ufdc_assertions
bind ufdc_top ufdc_assertions u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pslverr_o(pslverr_o),
  .tx_valid_o(tx_valid_o), .rx_full_o(rx_full_o), .tx_dma_request_n_o(tx_dma_request_n_o),
  .rx_dma_request_n_o(rx_dma_request_n_o), .rx_data_irq_o(rx_data_irq_o),
  .tx_empty_irq_o(tx_empty_irq_o), .fifo_enabled_o(fifo_enabled_o)
);

// File: sim/ufdc_host_model.sv
// Host bus master model on the APB side of the block
`timescale 1ns/100ps
`include "ufdc_params.svh"
module ufdc_host_model (
  // Clock
  input  wire logic                    sys_clk_i,
  // APB master
  output logic                         psel_o,
  output logic                         penable_o,
  output logic                         pwrite_o,
  output logic [`UFDC_ADDR_W-1:0]      paddr_o,
  output logic [31:0]                  pwdata_o,
  input  wire logic [31:0]             prdata_i,
  input  wire logic                    pready_i,
  input  wire logic                    pslverr_i
);
  import ufdc_pkg::*;
  // Idle bus at time zero
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = '0;
    pwdata_o  = '0;
  end
  // One transfer; request held until pready is seen high at an edge
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge sys_clk_i);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= a;
    pwdata_o <= wd;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    do @(posedge sys_clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // Released lines show no stale value
    paddr_o   <= ~a;
    pwdata_o  <= ~wd;
  endtask : xfer
  // Control write; enable always set so the other bits are taken
  task ctl(input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, `UFDC_OFF_FCTL, {24'h0, v | 8'h01}, d, e);
  endtask : ctl
endmodule : ufdc_host_model
